// *** logic/alert_map.svh ***
// Register offsets, field positions, reset values and timing counts of the alert block
`ifndef ALERT_MAP_SVH
`define ALERT_MAP_SVH

// ==========================================================
// Threshold registers
`define ADDR_VBAT_LO_THR 8'h01
`define ADDR_VBAT_HI_THR 8'h02
`define ADDR_VIN_LO_THR 8'h03
`define ADDR_VIN_HI_THR 8'h04
`define ADDR_VSYS_LO_THR 8'h05
`define ADDR_VSYS_HI_THR 8'h06
`define ADDR_IIN_HI_THR 8'h07
`define ADDR_IBAT_LO_THR 8'h08
`define ADDR_DIE_HI_THR 8'h09
`define ADDR_BSR_HI_THR 8'h0a
`define ADDR_NTC_HI_THR 8'h0b
`define ADDR_NTC_LO_THR 8'h0c
`define ADDR_QCOUNT_LO_THR 8'h10
`define ADDR_QCOUNT_HI_THR 8'h11

// ==========================================================
// Enable, flag and status registers
`define ADDR_LIMIT_EN 8'h0d
`define ADDR_PHASE_EN 8'h0e
`define ADDR_LOOP_EN 8'h0f
`define ADDR_LIMIT_FLAGS 8'h36
`define ADDR_MEAS_VALID 8'h4a
`define ADDR_PHASE_FLAGS 8'h50
`define ADDR_LOOP_FLAGS 8'h51
`define ADDR_LIVE_STATUS 8'h52

// ==========================================================
// Field positions and widths
`define BIT_MEAS_VALID 15
`define PHASE_W 11
`define LOOP_W 4
`define BIT_EQUALIZE 10
`define BIT_ABSORB 9
`define BIT_PRECHARGE 7
`define BIT_NTC_PAUSE 5
`define BIT_TIMER_TERM 4
`define BIT_CX_TERM 3
`define BIT_MAX_TIME 2
`define LIMIT_MASK 16'hbfff
`define RESET_WORD 16'h0000

// ==========================================================
// Timing
`define CLK_HZ 50000000
`define WARMUP_MS 12
`define WARMUP_CYCLES ((`WARMUP_MS * `CLK_HZ) / 1000)

`endif

// *** logic/alert_pkg.sv ***
// Types shared by the alert block
package alert_pkg;

  // ==========================================================
  // Measurement channels
  typedef enum logic [3:0] {
    CH_VBAT = 4'h0,
    CH_VIN = 4'h1,
    CH_VSYS = 4'h2,
    CH_IBAT = 4'h3,
    CH_IIN = 4'h4,
    CH_DIE = 4'h5,
    CH_NTC = 4'h6,
    CH_BSR = 4'h7,
    CH_QCOUNT = 4'h8
  } meas_chan_t;

  // ==========================================================
  // Battery chemistry
  typedef enum logic [1:0] {
    CHEM_LI_ION = 2'h0,
    CHEM_LIFEPO4 = 2'h1,
    CHEM_LEAD_ACID = 2'h2
  } chem_t;

  // ==========================================================
  // Warm-up state
  typedef enum logic {
    WARM_RUN = 1'b0,
    WARM_DONE = 1'b1
  } warm_state_t;

endpackage

// *** logic/sample_if.sv ***
// Measurement sample bundle passed to the limit comparators
`timescale 1ns/1ps
`default_nettype none
interface sample_if;
  import alert_pkg::*;
  logic strobe;
  meas_chan_t chan;
  logic [15:0] value;
  modport src (output strobe, output chan, output value);
  modport sink (input strobe, input chan, input value);
endinterface
`default_nettype wire

// *** logic/limit_cmp.sv ***
// One signed threshold comparison against a new measurement result
`timescale 1ns/1ps
`default_nettype none
module limit_cmp #(
  parameter alert_pkg::meas_chan_t CHAN = alert_pkg::CH_VBAT,
  parameter bit HIGH = 1'b1
) (
  // Sample
  sample_if.sink smp,
  // Threshold and result
  input wire logic [15:0] limit,
  output logic hit
);
  import alert_pkg::*;

  // ==========================================================
  // Strictly above a high limit or strictly below a low limit
  always_comb begin
    hit = 1'b0;
    if (smp.strobe && (smp.chan == CHAN)) begin
      if (HIGH) begin
        hit = $signed(smp.value) > $signed(limit);
      end else begin
        hit = $signed(smp.value) < $signed(limit);
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/warmup_timer.sv ***
// Measurement warm-up timer giving the ready level and its rising pulse
`timescale 1ns/1ps
`default_nettype none
module warmup_timer #(
  parameter int unsigned CYCLES = 600000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Status
  output logic ready,
  output logic ready_rise
);
  import alert_pkg::*;

  logic [23:0] cnt_q;
  warm_state_t state_q;

  // ==========================================================
  // Count out the warm-up once after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h000000;
      state_q <= WARM_RUN;
      ready_rise <= 1'b0;
    end else begin
      ready_rise <= 1'b0;
      unique case (state_q)
        WARM_RUN: begin
          if (cnt_q == 24'(CYCLES - 1)) begin
            state_q <= WARM_DONE;
            ready_rise <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 24'h000001;
          end
        end
        WARM_DONE: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  assign ready = (state_q == WARM_DONE);
endmodule
`default_nettype wire

// *** logic/charger_telemetry_alert_ctrl.sv ***
// Programmable alert controller of the charger telemetry system
//
// Behaviour
// [RQ1] System-rail low and high signed thresholds detect the rail leaving the window.
// [RQ2] Input-current high signed threshold detects input current above it.
// [RQ3] Battery-current low signed threshold, discharge negative, detects current below it.
// [RQ4] Die-temperature high threshold in die code format detects codes above it.
// [RQ5] Series-resistance high threshold detects computed results above it.
// [RQ6] Thermistor ratio above high means cold, below low means hot.
// [RQ7] Limit enable bits: 15 valid, 13..0 per-limit as mapped.
// [RQ8] Enabled strict excursion sets the matching limit flag and asserts alert.
// [RQ9] Enabled excursions appear on the alert line and the limit flag register.
// [RQ10] Measurements become valid after about 12 ms; enabled, that raises an alert.
// [RQ11] Charger is held off until warm-up ends, whatever the valid enable.
// [RQ12] Charger-phase enable bits 10..0: equalize down to battery short.
// [RQ13] Phase alerts while in phase; equalize lead-acid only, absorb not lithium-ion.
// [RQ14] Precharge alert applies to lithium-ion below 2.9 V per cell.
// [RQ15] Thermistor pause alert applies to lithium chemistries only.
// [RQ16] Timer termination and max-time fault alerts apply to lithium chemistries.
// [RQ17] Current-threshold termination alert applies to lithium chemistries.
// [RQ18] Battery short and missing faults come from the detection phase.
// [RQ19] Loop enable bits: 3 undervoltage, 2 input current, 1 charge current, 0 voltage.
// [RQ20] Enabled loop alerts while that loop governs charger current.
// [RQ21] Battery-voltage low and high signed thresholds.
// [RQ22] Input-voltage low and high thresholds.
// [RQ23] Charge-count low and high thresholds in the accumulator format.
// [RQ24] Measurement-valid status bit 0 reads 1 once telemetry is ready.
// [RQ25] Flags stay set until software clears; alert holds while any flag set.
// [RQ26] Comparisons are signed 16-bit on each newly completed result.
`include "alert_map.svh"
`timescale 1ns/1ps
`default_nettype none
module charger_telemetry_alert_ctrl #(
  parameter int unsigned WARMUP_CYCLES = `WARMUP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Measurement results
  input wire logic meas_strobe,
  input wire alert_pkg::meas_chan_t meas_chan,
  input wire logic [15:0] meas_value,
  // Charger condition
  input wire alert_pkg::chem_t chem,
  input wire logic [10:0] charger_phase,
  input wire logic [3:0] regulation_loop,
  // Status
  output logic meas_sys_valid,
  output logic charger_run_ok,
  // Alert pin, open drain
  output logic smbalert_o,
  output logic smbalert_oe
);
  import alert_pkg::*;

  localparam int NLIM = 14;

  // ==========================================================
  // Limit table, one entry per limit enable bit 13..0
  localparam logic [7:0] LIM_ADDR [NLIM] = '{
    `ADDR_NTC_LO_THR, `ADDR_NTC_HI_THR, `ADDR_BSR_HI_THR, `ADDR_DIE_HI_THR,
    `ADDR_IBAT_LO_THR, `ADDR_IIN_HI_THR, `ADDR_VSYS_HI_THR, `ADDR_VSYS_LO_THR,
    `ADDR_VIN_HI_THR, `ADDR_VIN_LO_THR, `ADDR_VBAT_HI_THR, `ADDR_VBAT_LO_THR,
    `ADDR_QCOUNT_HI_THR, `ADDR_QCOUNT_LO_THR
  };
  localparam meas_chan_t LIM_CHAN [NLIM] = '{
    CH_NTC, CH_NTC, CH_BSR, CH_DIE, CH_IBAT, CH_IIN, CH_VSYS, CH_VSYS,
    CH_VIN, CH_VIN, CH_VBAT, CH_VBAT, CH_QCOUNT, CH_QCOUNT
  };
  localparam bit LIM_HIGH [NLIM] = '{
    1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0
  };

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // Declarations
  logic [15:0] thr_q [NLIM];
  logic [15:0] limit_en_q;
  logic [`PHASE_W-1:0] phase_en_q;
  logic [`LOOP_W-1:0] loop_en_q;
  logic [15:0] limit_flag_q;
  logic [15:0] limit_flag_d;
  logic [`PHASE_W-1:0] phase_flag_q;
  logic [`PHASE_W-1:0] phase_flag_d;
  logic [`LOOP_W-1:0] loop_flag_q;
  logic [`LOOP_W-1:0] loop_flag_d;
  logic [NLIM-1:0] lim_hit;
  logic [15:0] limit_set;
  logic [`PHASE_W-1:0] phase_live;
  logic [`LOOP_W-1:0] loop_live;
  logic warm_ready;
  logic warm_rise;
  logic alert_q;
  logic [15:0] rdata_d;
  logic is_lithium;

  sample_if smp ();

  // ==========================================================
  // Sample bundle towards the comparators
  assign smp.strobe = meas_strobe;
  assign smp.chan = meas_chan;
  assign smp.value = meas_value;

  // ==========================================================
  // Threshold registers and their comparators
  for (genvar i = 0; i < NLIM; i++) begin : g_lim
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        thr_q[i] <= `RESET_WORD;
      end else if (reg_wr && (reg_addr == LIM_ADDR[i])) begin
        thr_q[i] <= reg_wdata; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ21] [RQ22] [RQ23]
      end
    end

    limit_cmp #(
      .CHAN(LIM_CHAN[i]),
      .HIGH(LIM_HIGH[i])
    ) u_cmp (
      .smp(smp.sink),
      .limit(thr_q[i]),
      .hit(lim_hit[i]) // [RQ26]
    );
  end

  // ==========================================================
  // Enable registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_en_q <= `RESET_WORD;
    end else if (reg_wr && (reg_addr == `ADDR_LIMIT_EN)) begin
      limit_en_q <= reg_wdata & `LIMIT_MASK; // [RQ7]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_en_q <= `PHASE_W'(`RESET_WORD);
    end else if (reg_wr && (reg_addr == `ADDR_PHASE_EN)) begin
      phase_en_q <= reg_wdata[`PHASE_W-1:0]; // [RQ12]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_en_q <= `LOOP_W'(`RESET_WORD);
    end else if (reg_wr && (reg_addr == `ADDR_LOOP_EN)) begin
      loop_en_q <= reg_wdata[`LOOP_W-1:0]; // [RQ19]
    end
  end

  // ==========================================================
  // Measurement warm-up
  warmup_timer #(
    .CYCLES(WARMUP_CYCLES)
  ) u_warm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ready(warm_ready), // [RQ10]
    .ready_rise(warm_rise)
  );

  assign meas_sys_valid = warm_ready; // [RQ24]
  assign charger_run_ok = warm_ready; // [RQ11]

  // ==========================================================
  // Limit flag events
  always_comb begin
    limit_set = 16'h0000;
    limit_set[NLIM-1:0] = lim_hit & limit_en_q[NLIM-1:0]; // [RQ8]
    limit_set[`BIT_MEAS_VALID] = warm_rise & limit_en_q[`BIT_MEAS_VALID]; // [RQ10]
  end

  // ==========================================================
  // Charger phase qualification by chemistry
  assign is_lithium = (chem == CHEM_LI_ION) || (chem == CHEM_LIFEPO4);

  always_comb begin
    phase_live = charger_phase; // [RQ18]
    if (chem != CHEM_LEAD_ACID) begin
      phase_live[`BIT_EQUALIZE] = 1'b0; // [RQ13]
    end
    if (chem == CHEM_LI_ION) begin
      phase_live[`BIT_ABSORB] = 1'b0; // [RQ13]
    end
    if (chem != CHEM_LI_ION) begin
      phase_live[`BIT_PRECHARGE] = 1'b0; // [RQ14]
    end
    if (!is_lithium) begin
      phase_live[`BIT_NTC_PAUSE] = 1'b0; // [RQ15]
      phase_live[`BIT_TIMER_TERM] = 1'b0; // [RQ16]
      phase_live[`BIT_MAX_TIME] = 1'b0; // [RQ16]
      phase_live[`BIT_CX_TERM] = 1'b0; // [RQ17]
    end
  end

  // Loop-in-control bits need no qualification
  assign loop_live = regulation_loop;

  // ==========================================================
  // Sticky flags, a set in the clearing cycle wins
  always_comb begin
    limit_flag_d = limit_flag_q;
    if (reg_wr && (reg_addr == `ADDR_LIMIT_FLAGS)) begin
      limit_flag_d = limit_flag_q & reg_wdata; // [RQ25]
    end
    limit_flag_d = limit_flag_d | limit_set; // [RQ9]
  end

  always_comb begin
    phase_flag_d = phase_flag_q;
    if (reg_wr && (reg_addr == `ADDR_PHASE_FLAGS)) begin
      phase_flag_d = phase_flag_q & reg_wdata[`PHASE_W-1:0]; // [RQ25]
    end
    phase_flag_d = phase_flag_d | (phase_live & phase_en_q); // [RQ13]
  end

  always_comb begin
    loop_flag_d = loop_flag_q;
    if (reg_wr && (reg_addr == `ADDR_LOOP_FLAGS)) begin
      loop_flag_d = loop_flag_q & reg_wdata[`LOOP_W-1:0]; // [RQ25]
    end
    loop_flag_d = loop_flag_d | (loop_live & loop_en_q); // [RQ20]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_flag_q <= `RESET_WORD;
    end else begin
      limit_flag_q <= limit_flag_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_flag_q <= `PHASE_W'(`RESET_WORD);
      loop_flag_q <= `LOOP_W'(`RESET_WORD);
    end else begin
      phase_flag_q <= phase_flag_d;
      loop_flag_q <= loop_flag_d;
    end
  end

  // ==========================================================
  // Alert line, pulled low while any flag stands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= (|limit_flag_d) | (|phase_flag_d) | (|loop_flag_d); // [RQ9] [RQ25]
    end
  end

  assign smbalert_o = 1'b0;
  assign smbalert_oe = alert_q;

  // ==========================================================
  // Read data
  always_comb begin
    rdata_d = 16'h0000;
    for (int k = 0; k < NLIM; k++) begin
      if (reg_addr == LIM_ADDR[k]) begin
        rdata_d = thr_q[k];
      end
    end
    case (reg_addr)
      `ADDR_LIMIT_EN: begin
        rdata_d = limit_en_q;
      end
      `ADDR_PHASE_EN: begin
        rdata_d = 16'(phase_en_q);
      end
      `ADDR_LOOP_EN: begin
        rdata_d = 16'(loop_en_q);
      end
      `ADDR_LIMIT_FLAGS: begin
        rdata_d = limit_flag_q;
      end
      `ADDR_PHASE_FLAGS: begin
        rdata_d = 16'(phase_flag_q);
      end
      `ADDR_LOOP_FLAGS: begin
        rdata_d = 16'(loop_flag_q);
      end
      `ADDR_MEAS_VALID: begin
        rdata_d = {15'h0000, warm_ready}; // [RQ24]
      end
      `ADDR_LIVE_STATUS: begin
        rdata_d = {1'b0, loop_live, phase_live};
      end
      default: begin
        rdata_d = rdata_d;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// *** sim/alert_ctrl_chk.sv ***
// Assertion checker for the charger telemetry alert controller
`timescale 1ns/1ps
`default_nettype none
module alert_ctrl_chk #(
  parameter int unsigned WARMUP_CYCLES = 600000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic meas_strobe,
  input wire logic [10:0] charger_phase,
  input wire logic [3:0] regulation_loop,
  input wire logic meas_sys_valid,
  input wire logic charger_run_ok,
  input wire logic smbalert_o,
  input wire logic smbalert_oe
);
  logic [31:0] rel_cnt_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Cycles since reset release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      rel_cnt_q <= 32'h0;
    else if (rel_cnt_q != 32'hffff_ffff)
      rel_cnt_q <= rel_cnt_q + 32'h1;
  end
  run_gate_a: assert property (charger_run_ok == meas_sys_valid)
    else $error("charger permit differs from valid");
  drain_low_a: assert property (smbalert_o == 1'b0)
    else $error("alert data not low");
  warm_time_a: assert property ($rose(meas_sys_valid) |->
    rel_cnt_q >= WARMUP_CYCLES + 1 && rel_cnt_q <= WARMUP_CYCLES + 3)
    else $error("warm-up length wrong");
  valid_keep_a: assert property (meas_sys_valid |=> meas_sys_valid)
    else $error("valid dropped");
  en_bit14_a: assert property (reg_rd && reg_addr == 8'h0d |=> reg_rdata[14] == 1'b0)
    else $error("limit enable bit 14 not zero");
  phase_width_a: assert property (reg_rd && reg_addr == 8'h0e |=>
    reg_rdata[15:11] == 5'h0)
    else $error("phase enable upper bits set");
  loop_width_a: assert property (reg_rd && reg_addr == 8'h0f |=>
    reg_rdata[15:4] == 12'h0)
    else $error("loop enable upper bits set");
  valid_read_a: assert property (reg_rd && reg_addr == 8'h4a |=>
    reg_rdata == {15'h0, $past(meas_sys_valid)})
    else $error("valid status read wrong");
  alert_hold_a: assert property (smbalert_oe && !reg_wr |=> smbalert_oe)
    else $error("alert released without a clear");
  alert_cause_a: assert property ($rose(smbalert_oe) |-> $past(meas_strobe) ||
    ($past(meas_sys_valid) && !$past(meas_sys_valid, 2)) ||
    ($past(charger_phase) != 11'h000) || ($past(regulation_loop) != 4'h0))
    else $error("alert raised without cause");
  read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule
bind charger_telemetry_alert_ctrl alert_ctrl_chk #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_strobe(meas_strobe),
  .charger_phase(charger_phase), .regulation_loop(regulation_loop),
  .meas_sys_valid(meas_sys_valid), .charger_run_ok(charger_run_ok),
  .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));
`default_nettype wire

// *** sim/host_model.sv ***
// Host controller model: register accesses and the pulled-up alert wire
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Alert pin
  input wire logic smbalert_o,
  input wire logic smbalert_oe,
  output logic alert_n
);
  // Open-drain wire with pull-up
  assign alert_n = smbalert_oe ? smbalert_o : 1'b1;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Testbench of the charger telemetry alert controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import alert_pkg::*;
  logic sys_clk, rstn, reg_wr, reg_rd, meas_strobe, meas_sys_valid, charger_run_ok;
  logic smbalert_o, smbalert_oe, alert_n, e;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, meas_value, rv, thr, trip;
  meas_chan_t meas_chan;
  chem_t chem;
  logic [10:0] charger_phase;
  logic [3:0] regulation_loop;
  int errors, total_checks, i, b, c;
  logic [7:0] ad [14] = '{8'h10, 8'h11, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                          8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  logic [3:0] ch [14] = '{4'h8, 4'h8, 4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2,
                          4'h4, 4'h3, 4'h5, 4'h7, 4'h6, 4'h6};
  logic [13:0] hm = 14'b01110110101010;
  charger_telemetry_alert_ctrl #(.WARMUP_CYCLES(20)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_strobe(meas_strobe),
    .meas_chan(meas_chan), .meas_value(meas_value), .chem(chem),
    .charger_phase(charger_phase), .regulation_loop(regulation_loop),
    .meas_sys_valid(meas_sys_valid), .charger_run_ok(charger_run_ok),
    .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));
  host_model u_host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smbalert_o(smbalert_o),
    .smbalert_oe(smbalert_oe), .alert_n(alert_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic achk(input logic x);
    chk({14'h0, smbalert_oe, ~alert_n}, {14'h0, x, x});
  endtask
  task automatic smp(input logic [3:0] k, input logic [15:0] v);
    @(negedge sys_clk);
    meas_strobe = 1'b1;
    meas_chan = meas_chan_t'(k);
    meas_value = v;
    @(negedge sys_clk);
    meas_strobe = 1'b0;
    meas_value = ~v;
  endtask
  task automatic pulse(input logic [10:0] ph, input logic [3:0] lp);
    @(negedge sys_clk);
    charger_phase = ph;
    regulation_loop = lp;
    @(negedge sys_clk);
    charger_phase = 11'h0;
    regulation_loop = 4'h0;
  endtask
  function automatic logic phase_ok(input int k, input int n);
    case (n)
      10: return k == 2;
      9: return k != 0;
      7: return k == 0;
      5, 4, 3, 2: return k != 2;
      default: return 1'b1;
    endcase
  endfunction
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    meas_strobe = 1'b0;
    meas_chan = CH_VBAT;
    meas_value = 16'h0;
    chem = CHEM_LI_ION;
    charger_phase = 11'h0;
    regulation_loop = 4'h0;
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    u_host.wr(8'h0d, 16'h8000);
    chk({15'h0, charger_run_ok}, 16'h0);
    rchk(8'h4a, 16'h0);
    for (i = 0; i < 40 && meas_sys_valid !== 1'b1; i++) @(negedge sys_clk);
    chk({15'h0, charger_run_ok}, 16'h1);
    rchk(8'h4a, 16'h1);
    rchk(8'h36, 16'h8000);
    achk(1'b1);
    u_host.wr(8'h36, 16'h7fff);
    achk(1'b0);
    for (i = 0; i < 14; i++) begin
      rchk(ad[i], 16'h0);
      u_host.wr(ad[i], {ad[i], ~ad[i]});
      rchk(ad[i], {ad[i], ~ad[i]});
    end
    u_host.wr(8'h0d, 16'hffff);
    rchk(8'h0d, 16'hbfff);
    u_host.wr(8'h0e, 16'hffff);
    rchk(8'h0e, 16'h07ff);
    u_host.wr(8'h0f, 16'hffff);
    rchk(8'h0f, 16'h000f);
    u_host.wr(8'h0d, 16'h0);
    u_host.wr(8'h0e, 16'h0);
    u_host.wr(8'h0f, 16'h0);
    u_host.wr(8'h20, 16'h1234);
    rchk(8'h20, 16'h0);
    u_host.wr(8'h4a, 16'h0);
    rchk(8'h4a, 16'h1);
    rchk(8'h36, 16'h0);
    for (i = 0; i < 14; i++) begin
      b = 13 - i;
      thr = hm[i] ? 16'hfffb : 16'h0001;
      trip = hm[i] ? 16'h0001 : 16'hffff;
      u_host.wr(ad[i], thr);
      smp(ch[i], trip);
      rchk(8'h36, 16'h0);
      u_host.wr(8'h0d, 16'h1 << b);
      smp(ch[i], thr);
      rchk(8'h36, 16'h0);
      smp(ch[i], trip);
      achk(1'b1);
      rchk(8'h36, 16'h1 << b);
      achk(1'b1);
      u_host.wr(8'h36, ~(16'h1 << b));
      achk(1'b0);
      u_host.wr(8'h0d, 16'h0);
    end
    pulse(11'h7ff, 4'hf);
    rchk(8'h50, 16'h0);
    rchk(8'h51, 16'h0);
    u_host.wr(8'h0e, 16'h07ff);
    for (c = 0; c < 3; c++) begin
      chem = chem_t'(c);
      for (b = 0; b < 11; b++) begin
        e = phase_ok(c, b);
        pulse(11'h1 << b, 4'h0);
        rchk(8'h50, e ? 16'h1 << b : 16'h0);
        achk(e);
        u_host.wr(8'h50, 16'h0);
      end
    end
    u_host.wr(8'h0f, 16'h000f);
    for (b = 0; b < 4; b++) begin
      pulse(11'h0, 4'h1 << b);
      rchk(8'h51, 16'h1 << b);
      achk(1'b1);
      u_host.wr(8'h51, 16'h0);
      achk(1'b0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
